// File: hw/sct_regs.svh
// constants of the system counter and timer block: sizes, offsets, bit positions, ids
// included by the package and by every design file; definitions only
`ifndef SCT_REGS_SVH
`define SCT_REGS_SVH

`define SCT_NCORE         2
`define SCT_NSLOT         7
`define SCT_NENT          15
`define SCT_WAKE_ENT      4'he
`define SCT_ENT_W         4
`define SCT_CNT_W         64

// counter runs at the core clock rate
`define SCT_CLK_HZ        32'h0ee6b280
`define SCT_MIN_CNT_HZ    32'h00989680
`define SCT_TIDR_VAL      32'h00000001

// per-core interrupt ids; outputs carry ids 16..31, bit = id - base
`define SCT_ID_BASE       5'h10
`define SCT_ID_NS_PHYS    5'h1e
`define SCT_ID_SEC_PHYS   5'h1d
`define SCT_ID_HYP_VIRT   5'h1c
`define SCT_ID_VIRT       5'h1b
`define SCT_ID_HYP_PHYS   5'h1a
`define SCT_ID_MAINT      5'h19
`define SCT_ID_XTRIG      5'h18
`define SCT_ID_PMU        5'h17
`define SCT_ID_DCC        5'h16
`define SCT_ID_PROF       5'h15
`define SCT_ID_SHYP_PHYS  5'h14
`define SCT_ID_SHYP_VIRT  5'h13
`define SCT_HAS_HYP_VIRT  1'b1
`define SCT_HAS_SEC_HYP   1'b1

// counter control frame
`define SCT_CC_CR         12'h000
`define SCT_CC_SR         12'h004
`define SCT_CC_CV_LO      12'h008
`define SCT_CC_CV_HI      12'h00c
`define SCT_CC_FID0       12'h020
// counter read frame
`define SCT_RD_CV_LO      12'h000
`define SCT_RD_CV_HI      12'h004
// timer control frame
`define SCT_TC_FRQ        12'h000
`define SCT_TC_NSAR       12'h004
`define SCT_TC_TIDR       12'h008
`define SCT_TC_VOFF_LO    12'h080
`define SCT_TC_VOFF_HI    12'h084
// per-timer frame, also used for the per-core timers
`define SCT_PT_PCT_LO     12'h000
`define SCT_PT_PCT_HI     12'h004
`define SCT_PT_FRQ        12'h010
`define SCT_PT_CVAL_LO    12'h020
`define SCT_PT_CVAL_HI    12'h024
`define SCT_PT_TVAL       12'h028
`define SCT_PT_CTL        12'h02c

`define SCT_CR_EN         0
`define SCT_SR_RUN        0
`define SCT_CTL_EN        0
`define SCT_CTL_MASK      1
`define SCT_CTL_STAT      2

`endif

// File: hw/sct_pkg.sv
// types shared by the system counter and timer files
// assumes sct_regs.svh on the include path
`include "sct_regs.svh"
package sct_pkg;
  typedef enum logic [2:0] {
    SCT_FR_CNT_CTRL,
    SCT_FR_CNT_READ,
    SCT_FR_TMR_CTRL,
    SCT_FR_WAKE,
    SCT_FR_CORE
  } sct_frame_t;

  typedef enum logic {
    SCT_ACC_IDLE,
    SCT_ACC_MEMRD
  } sct_acc_state_t;
endpackage

// File: hw/sct_mem_if.sv
// carrier between the timer core and its compare-value store
// assumes one clock shared by both ends
`timescale 1ns/1ps
`include "sct_regs.svh"
interface sct_mem_if;
  logic                      we;
  logic [1:0]                wmask;
  logic [`SCT_ENT_W-1:0]     waddr;
  logic [`SCT_CNT_W-1:0]     wdata;
  logic [`SCT_ENT_W-1:0]     raddr;
  logic [`SCT_CNT_W-1:0]     rdata;
  modport ctrl (output we, wmask, waddr, wdata, raddr, input rdata);
  modport mem  (input we, wmask, waddr, wdata, raddr, output rdata);
endinterface

// File: hw/sct_cmp_mem.sv
// compare-value store: one 64-bit word per timer, half-word write mask
// read data registered one cycle after the address; a write and read of
// the same word in one cycle returns the old value
`timescale 1ns/1ps
`include "sct_regs.svh"
module sct_cmp_mem (
  input  wire logic i_clk,
  sct_mem_if.mem    mem
);
  logic [`SCT_CNT_W-1:0] store [`SCT_NENT];
  logic [`SCT_CNT_W-1:0] rdata;

  always_ff @(posedge i_clk) begin
    if (mem.we && mem.wmask[0]) begin
      store[mem.waddr][31:0] <= mem.wdata[31:0];
    end
    if (mem.we && mem.wmask[1]) begin
      store[mem.waddr][63:32] <= mem.wdata[63:32];
    end
    rdata <= store[mem.raddr];
  end

  assign mem.rdata = rdata;
endmodule

// File: hw/sct_top.sv
// system counter, per-core timers and memory-mapped wakeup timer
// assumes a plain single-beat frame access port and level interrupt inputs
// How it works
// [R1] non-secure physical to id 30, secure to 29
// [R2] hypervisor virtual timer drives id 28
// [R3] virtual to 27, hypervisor physical to 26
// [R4] secure hypervisor physical 20, virtual 19
// [R5] ids 25..21 carry the other core sources
// [R6] counter ticks at least ten megahertz
// [R7] counter never wraps within ten years
// [R8] counter is full 64 bits wide
// [R9] count value distributed to every core timer
// [R10] programmable compare per timer raises core interrupt
// [R11] memory-mapped wakeup timer always available
// [R12] wakeup expiry gives shared or message interrupt
// [R13] wakeup frame has no virtual timer; virtual offset reads zero
// [R14] virtual offset writes change nothing
// [R15] wakeup timer reachable from non-secure space
// [R16] frame security: control secure, timer frames open except core timer slots 1, 5, 6, which are secure only
// [R17] timer frame: compare halves, down-count, control
// [R18] control frame: count halves, control, status
// [R19] expired while count at or past compare
// [R20] 64-bit count read never mixes increments
`timescale 1ns/1ps
`include "sct_regs.svh"
module sct_top (
  input  wire logic                          i_clk,
  input  wire logic                          i_rst,
  input  wire logic                          i_acc_valid,
  input  wire logic                          i_acc_write,
  input  wire logic                          i_acc_secure,
  input  wire logic [2:0]                    i_acc_frame,
  input  wire logic [`SCT_ENT_W-1:0]         i_acc_timer,
  input  wire logic [11:0]                   i_acc_offset,
  input  wire logic [31:0]                   i_acc_wdata,
  input  wire logic [`SCT_NCORE-1:0]         i_maint_irq,
  input  wire logic [`SCT_NCORE-1:0]         i_cross_trigger_irq,
  input  wire logic [`SCT_NCORE-1:0]         i_pmu_irq,
  input  wire logic [`SCT_NCORE-1:0]         i_debug_comms_irq,
  input  wire logic [`SCT_NCORE-1:0]         i_profiling_buffer_irq,
  output logic                               o_acc_ready,
  output logic                               o_acc_done,
  output logic [31:0]                        o_acc_rdata,
  output logic [`SCT_CNT_W-1:0]              o_count,
  output logic [`SCT_NCORE-1:0][15:0]        o_per_core_interrupt,
  output logic                               o_wakeup_spi,
  output logic                               o_message_based_interrupt
);
  sct_mem_if mif ();

  sct_cmp_mem u_mem (
    .i_clk (i_clk),
    .mem   (mif)
  );

  logic [`SCT_CNT_W-1:0]    count,     next_count;
  logic                     cnt_en,    next_cnt_en;
  logic [31:0]              frq,       next_frq;
  logic [31:0]              nsar,      next_nsar;
  logic [31:0]              hi_latch,  next_hi_latch;
  logic [`SCT_NENT-1:0]     t_en,      next_t_en;
  logic [`SCT_NENT-1:0]     t_mask,    next_t_mask;
  logic [`SCT_NENT-1:0]     expired,   next_expired;
  logic [`SCT_ENT_W-1:0]    scan_idx,  next_scan_idx;
  logic [`SCT_ENT_W-1:0]    scan_ent,  next_scan_ent;
  logic                     scan_vld,  next_scan_vld;
  sct_pkg::sct_acc_state_t  acc_st,    next_acc_st;
  logic [`SCT_ENT_W-1:0]    acc_ent,   next_acc_ent;
  logic [11:0]              acc_off,   next_acc_off;
  logic                     ready,     next_ready;
  logic                     done,      next_done;
  logic [31:0]              rdata,     next_rdata;
  logic [`SCT_NCORE-1:0][15:0] per_core_interrupt,    next_ppi;
  logic                     wake,      next_wake;
  logic                     msg,       next_msg;

  // slot of an entry within its core; with two cores one subtraction is enough
  function automatic logic [2:0] ent_slot(input logic [`SCT_ENT_W-1:0] e);
    logic [`SCT_ENT_W-1:0] t;
    t = (e >= `SCT_ENT_W'(`SCT_NSLOT)) ? e - `SCT_ENT_W'(`SCT_NSLOT) : e;
    return t[2:0];
  endfunction
  // secure-only core timers: secure phys, secure hyp phys, secure hyp virt
  function automatic logic slot_secure(input logic [2:0] s);
    return (s == 3'h1) || (s == 3'h5) || (s == 3'h6);
  endfunction
  function automatic logic [4:0] slot_id(input logic [2:0] s);
    case (s)
      3'h0:    return `SCT_ID_NS_PHYS;   // [R1]
      3'h1:    return `SCT_ID_SEC_PHYS;  // [R1]
      3'h2:    return `SCT_ID_HYP_VIRT;  // [R2]
      3'h3:    return `SCT_ID_VIRT;      // [R3]
      3'h4:    return `SCT_ID_HYP_PHYS;  // [R3]
      3'h5:    return `SCT_ID_SHYP_PHYS; // [R4]
      default: return `SCT_ID_SHYP_VIRT; // [R4]
    endcase
  endfunction
  function automatic logic slot_present(input logic [2:0] s);
    case (s)
      3'h2:         return `SCT_HAS_HYP_VIRT;
      3'h5, 3'h6:   return `SCT_HAS_SEC_HYP;
      default:      return 1'b1;
    endcase
  endfunction
  // access decode, combinational helpers
  sct_pkg::sct_frame_t   frame;
  logic [`SCT_ENT_W-1:0] req_ent;
  logic                  req_tmr;
  logic                  req_ok;
  logic                  req_mem;

  always_comb begin
    frame   = sct_pkg::sct_frame_t'(i_acc_frame);
    req_tmr = (frame == sct_pkg::SCT_FR_WAKE) || (frame == sct_pkg::SCT_FR_CORE);
    req_ent = (frame == sct_pkg::SCT_FR_WAKE) ? `SCT_WAKE_ENT : i_acc_timer;
    req_ok  = 1'b1;
    if (frame == sct_pkg::SCT_FR_CNT_CTRL) begin
      req_ok = i_acc_secure;                                 // [R16]
    end else if (frame == sct_pkg::SCT_FR_CORE) begin
      req_ok = (i_acc_timer < `SCT_WAKE_ENT)
               && slot_present(ent_slot(i_acc_timer))
               && (i_acc_secure || !slot_secure(ent_slot(i_acc_timer)));
    end else if (frame > sct_pkg::SCT_FR_CORE) begin
      req_ok = 1'b0;
    end
    // wakeup frame takes either security state [R15]
    req_mem = req_tmr && req_ok && !i_acc_write
              && ((i_acc_offset == `SCT_PT_CVAL_LO) || (i_acc_offset == `SCT_PT_CVAL_HI)
                  || (i_acc_offset == `SCT_PT_TVAL));
  end

  always_comb begin
    logic        take;
    logic [63:0] sx;
    take          = ready && i_acc_valid;
    sx            = {{32{i_acc_wdata[31]}}, i_acc_wdata};
    next_count    = cnt_en ? count + 64'h1 : count;          // [R6] [R7] [R8]
    next_cnt_en   = cnt_en;
    next_frq      = frq;
    next_nsar     = nsar;
    next_hi_latch = hi_latch;
    next_t_en     = t_en;
    next_t_mask   = t_mask;
    next_expired  = expired;
    next_acc_st   = acc_st;
    next_acc_ent  = acc_ent;
    next_acc_off  = acc_off;
    next_done     = 1'b0;
    next_rdata    = rdata;
    mif.we        = 1'b0;
    mif.wmask     = 2'h0;
    mif.waddr     = req_ent;
    mif.wdata     = {i_acc_wdata, i_acc_wdata};
    mif.raddr     = scan_idx;
    // scan result: one entry per cycle unless an access read takes the store port, dropped if rewritten meanwhile [R19]
    if (scan_vld) begin
      next_expired[scan_ent] = (count >= mif.rdata);
    end
    case (acc_st)
      sct_pkg::SCT_ACC_IDLE: begin
        if (take && req_mem) begin
          mif.raddr    = req_ent;
          next_acc_ent = req_ent;
          next_acc_off = i_acc_offset;
          next_acc_st  = sct_pkg::SCT_ACC_MEMRD;
        end else if (take) begin
          next_done  = 1'b1;
          next_rdata = 32'h0;
          if (!req_ok) begin
            next_rdata = 32'h0;
          end else if (frame == sct_pkg::SCT_FR_CNT_CTRL) begin
            case (i_acc_offset)                               // [R18]
              `SCT_CC_CR: begin
                if (i_acc_write) begin
                  next_cnt_en = i_acc_wdata[`SCT_CR_EN];
                end
                next_rdata[`SCT_CR_EN] = cnt_en;
              end
              `SCT_CC_SR:   next_rdata[`SCT_SR_RUN] = cnt_en;
              `SCT_CC_CV_LO: begin
                if (i_acc_write) begin
                  next_count[31:0] = i_acc_wdata;
                end
                next_rdata    = count[31:0];
                next_hi_latch = count[63:32];                 // [R20]
              end
              `SCT_CC_CV_HI: begin
                if (i_acc_write) begin
                  next_count[63:32] = i_acc_wdata;
                end
                next_rdata = hi_latch;                        // [R20]
              end
              `SCT_CC_FID0: next_rdata = `SCT_CLK_HZ;
              default:      next_rdata = 32'h0;
            endcase
          end else if (frame == sct_pkg::SCT_FR_CNT_READ) begin
            if (i_acc_offset == `SCT_RD_CV_LO) begin
              next_rdata    = count[31:0];
              next_hi_latch = count[63:32];                   // [R20]
            end else if (i_acc_offset == `SCT_RD_CV_HI) begin
              next_rdata = hi_latch;
            end
          end else if (frame == sct_pkg::SCT_FR_TMR_CTRL) begin
            case (i_acc_offset)
              `SCT_TC_FRQ: begin
                if (i_acc_write && i_acc_secure) begin        // [R16]
                  next_frq = i_acc_wdata;
                end
                next_rdata = frq;
              end
              `SCT_TC_NSAR: begin
                if (i_acc_write && i_acc_secure) begin
                  next_nsar = i_acc_wdata;
                end
                next_rdata = i_acc_secure ? nsar : 32'h0;
              end
              `SCT_TC_TIDR: next_rdata = `SCT_TIDR_VAL;
              // virtual offset: reads zero, writes dropped [R13] [R14]
              `SCT_TC_VOFF_LO, `SCT_TC_VOFF_HI: next_rdata = 32'h0;
              default:      next_rdata = 32'h0;
            endcase
          end else begin
            case (i_acc_offset)                               // [R17]
              `SCT_PT_PCT_LO: begin
                next_rdata    = count[31:0];
                next_hi_latch = count[63:32];                 // [R20]
              end
              `SCT_PT_PCT_HI: next_rdata = hi_latch;
              `SCT_PT_FRQ:    next_rdata = frq;
              `SCT_PT_CVAL_LO, `SCT_PT_CVAL_HI: begin
                mif.we    = 1'b1;                             // [R10]
                mif.wmask = (i_acc_offset == `SCT_PT_CVAL_LO) ? 2'h1 : 2'h2;
                next_expired[req_ent] = 1'b0;
              end
              `SCT_PT_TVAL: begin
                mif.we    = 1'b1;                             // [R17]
                mif.wmask = 2'h3;
                mif.wdata = count + sx;
                next_expired[req_ent] = 1'b0;
              end
              `SCT_PT_CTL: begin
                if (i_acc_write) begin
                  next_t_en[req_ent]   = i_acc_wdata[`SCT_CTL_EN];
                  next_t_mask[req_ent] = i_acc_wdata[`SCT_CTL_MASK];
                end
                next_rdata[`SCT_CTL_EN]   = t_en[req_ent];
                next_rdata[`SCT_CTL_MASK] = t_mask[req_ent];
                next_rdata[`SCT_CTL_STAT] = t_en[req_ent] && expired[req_ent];
              end
              default:        next_rdata = 32'h0;
            endcase
          end
        end
      end
      sct_pkg::SCT_ACC_MEMRD: begin
        next_done   = 1'b1;
        next_acc_st = sct_pkg::SCT_ACC_IDLE;
        case (acc_off)
          `SCT_PT_CVAL_LO: next_rdata = mif.rdata[31:0];
          `SCT_PT_CVAL_HI: next_rdata = mif.rdata[63:32];
          default: begin
            sx         = mif.rdata - count;
            next_rdata = sx[31:0];
          end
        endcase
      end
      default: next_acc_st = sct_pkg::SCT_ACC_IDLE;
    endcase

    // a cleared flag must not be revived by a stale scan of the old value
    if (mif.we && scan_vld && (mif.waddr == scan_ent)) begin
      next_expired[scan_ent] = 1'b0;
    end
    next_ready    = (next_acc_st == sct_pkg::SCT_ACC_IDLE);
    next_scan_vld = (mif.raddr == scan_idx) && !(mif.we && (mif.waddr == scan_idx));
    next_scan_ent = scan_idx;
    next_scan_idx = scan_idx;
    if (mif.raddr == scan_idx) begin
      next_scan_idx = (scan_idx == `SCT_WAKE_ENT) ? '0 : scan_idx + `SCT_ENT_W'(1);
    end
  end

  // interrupt outputs, all levels except the message pulse
  always_comb begin
    logic [`SCT_ENT_W-1:0] e;
    logic [4:0]            id;
    e        = '0;
    id       = '0;
    next_ppi = '0;
    for (int c = 0; c < `SCT_NCORE; c++) begin
      for (int s = 0; s < `SCT_NSLOT; s++) begin
        e  = `SCT_ENT_W'(c * `SCT_NSLOT + s);
        id = slot_id(3'(s)) - `SCT_ID_BASE;
        if (slot_present(3'(s))) begin
          next_ppi[c][id[3:0]] = expired[e] && t_en[e] && !t_mask[e]; // [R10] [R19]
        end
      end
      id = `SCT_ID_MAINT - `SCT_ID_BASE;                      // [R5]
      next_ppi[c][id[3:0]] = i_maint_irq[c];
      id = `SCT_ID_XTRIG - `SCT_ID_BASE;
      next_ppi[c][id[3:0]] = i_cross_trigger_irq[c];
      id = `SCT_ID_PMU - `SCT_ID_BASE;
      next_ppi[c][id[3:0]] = i_pmu_irq[c];
      id = `SCT_ID_DCC - `SCT_ID_BASE;
      next_ppi[c][id[3:0]] = i_debug_comms_irq[c];
      id = `SCT_ID_PROF - `SCT_ID_BASE;
      next_ppi[c][id[3:0]] = i_profiling_buffer_irq[c];
    end
    // wakeup timer stays usable whatever core power does [R11] [R12]
    next_wake = expired[`SCT_WAKE_ENT] && t_en[`SCT_WAKE_ENT] && !t_mask[`SCT_WAKE_ENT];
    next_msg  = next_wake && !wake;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      count    <= '0;
      cnt_en   <= 1'b0;
      frq      <= `SCT_CLK_HZ;
      nsar     <= 32'h0;
      hi_latch <= 32'h0;
      t_en     <= '0;
      t_mask   <= '0;
      expired  <= '0;
      scan_idx <= '0;
      scan_ent <= '0;
      scan_vld <= 1'b0;
      acc_st   <= sct_pkg::SCT_ACC_IDLE;
      acc_ent  <= '0;
      acc_off  <= 12'h0;
      ready    <= 1'b1;
      done     <= 1'b0;
      rdata    <= 32'h0;
      per_core_interrupt      <= '0;
      wake     <= 1'b0;
      msg      <= 1'b0;
    end else begin
      count    <= next_count;
      cnt_en   <= next_cnt_en;
      frq      <= next_frq;
      nsar     <= next_nsar;
      hi_latch <= next_hi_latch;
      t_en     <= next_t_en;
      t_mask   <= next_t_mask;
      expired  <= next_expired;
      scan_idx <= next_scan_idx;
      scan_ent <= next_scan_ent;
      scan_vld <= next_scan_vld;
      acc_st   <= next_acc_st;
      acc_ent  <= next_acc_ent;
      acc_off  <= next_acc_off;
      ready    <= next_ready;
      done     <= next_done;
      rdata    <= next_rdata;
      per_core_interrupt      <= next_ppi;
      wake     <= next_wake;
      msg      <= next_msg;
    end
  end

  assign o_count                   = count;                   // [R9]
  assign o_acc_ready               = ready;
  assign o_acc_done                = done;
  assign o_acc_rdata               = rdata;
  assign o_per_core_interrupt      = per_core_interrupt;
  assign o_wakeup_spi              = wake;                    // [R12]
  assign o_message_based_interrupt = msg;                     // [R12]
endmodule

// File: tb/sct_top_monitor.sv
// concurrent checks on the system counter and timer top ports
// bound to sct_top; one clock, synchronous active-high reset
`timescale 1ns/1ps
`include "sct_regs.svh"
module sct_top_monitor (
  input wire logic                          i_clk,
  input wire logic                          i_rst,
  input wire logic                          i_acc_valid,
  input wire logic                          i_acc_write,
  input wire logic                          i_acc_secure,
  input wire logic [`SCT_ENT_W-1:0]         i_acc_timer,
  input wire logic [2:0]                    i_acc_frame,
  input wire logic [11:0]                   i_acc_offset,
  input wire logic [`SCT_NCORE-1:0]         i_maint_irq,
  input wire logic [`SCT_NCORE-1:0]         i_cross_trigger_irq,
  input wire logic [`SCT_NCORE-1:0]         i_pmu_irq,
  input wire logic [`SCT_NCORE-1:0]         i_debug_comms_irq,
  input wire logic [`SCT_NCORE-1:0]         i_profiling_buffer_irq,
  input wire logic                          o_acc_ready,
  input wire logic                          o_acc_done,
  input wire logic [`SCT_CNT_W-1:0]         o_count,
  input wire logic [`SCT_NCORE-1:0][15:0]   o_per_core_interrupt,
  input wire logic                          o_wakeup_spi,
  input wire logic                          o_message_based_interrupt
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic                 slow_rd;
  logic [1:0][15:0]     pci;
  assign pci = o_per_core_interrupt;
  // compare and down-count reads go through the store, one extra cycle;
  // refused ones (secure-only slot from non-secure, bad entry) answer at once
  assign slow_rd = o_acc_ready && i_acc_valid && !i_acc_write
                   && i_acc_frame inside {3'h3, 3'h4}
                   && i_acc_offset inside {12'h020, 12'h024, 12'h028}
                   && (i_acc_frame == 3'h3 || (i_acc_timer < 4'he && (i_acc_secure
                       || !((i_acc_timer % 4'h7) inside {4'h1, 4'h5, 4'h6}))));
  a_maint_routed: assert property (!$past(i_rst) |->
    {pci[1][9], pci[0][9]} == $past(i_maint_irq)) else $error("maint id wrong");
  a_xtrig_routed: assert property (!$past(i_rst) |->
    {pci[1][8], pci[0][8]} == $past(i_cross_trigger_irq)) else $error("xtrig id wrong");
  a_pmu_routed: assert property (!$past(i_rst) |->
    {pci[1][7], pci[0][7]} == $past(i_pmu_irq)) else $error("pmu id wrong");
  a_dcc_routed: assert property (!$past(i_rst) |->
    {pci[1][6], pci[0][6]} == $past(i_debug_comms_irq)) else $error("dcc id wrong");
  a_prof_routed: assert property (!$past(i_rst) |->
    {pci[1][5], pci[0][5]} == $past(i_profiling_buffer_irq)) else $error("prof id wrong");
  a_slow_read: assert property (slow_rd |=> !o_acc_ready && !o_acc_done ##1 o_acc_done)
    else $error("compare read timing wrong");
  a_fast_answer: assert property (o_acc_ready && i_acc_valid && !slow_rd |=> o_acc_done)
    else $error("access not answered");
  // writes may load the count, so only idle cycles are checked
  a_count_step: assert property (!$past(i_rst) && !o_acc_done && !$past(o_acc_done) |->
    (o_count - $past(o_count)) <= 64'h1) else $error("count jumped");
  a_msg_on_rise: assert property ($rose(o_wakeup_spi) |-> ##[0:1] o_message_based_interrupt)
    else $error("no message on wakeup");
  a_msg_single: assert property (o_message_based_interrupt |=> !o_message_based_interrupt)
    else $error("message longer than a cycle");
  c_slow_read: cover property (slow_rd);
  c_wakeup: cover property ($rose(o_wakeup_spi));
  c_core_timer: cover property (|{pci[1][14:10], pci[1][4:3]});
endmodule

bind sct_top sct_top_monitor i_sct_top_monitor (.i_clk, .i_rst, .i_acc_valid, .i_acc_write,
  .i_acc_secure, .i_acc_timer, .i_acc_frame, .i_acc_offset, .i_maint_irq,
  .i_cross_trigger_irq, .i_pmu_irq, .i_debug_comms_irq, .i_profiling_buffer_irq, .o_acc_ready,
  .o_acc_done, .o_count, .o_per_core_interrupt, .o_wakeup_spi, .o_message_based_interrupt);

// File: tb/sct_core_src_model.sv
// other core-local interrupt sources: maintenance, cross trigger, pmu, dcc, profiling
// levels change only at the falling edge, as a core would drive them
`timescale 1ns/1ps
module sct_core_src_model (
  input  wire logic       i_clk,
  input  wire logic [9:0] i_lvl,
  output logic [9:0]      o_src
);
  always @(negedge i_clk) o_src <= i_lvl;
endmodule

// File: tb/system_counter_wakeup_timer_bench.sv
// self-checking bench for sct_top: counter, core timers, wakeup timer, core sources
// counter held stopped at a known value while timers are checked
`timescale 1ns/1ps
`include "sct_regs.svh"
module system_counter_wakeup_timer_bench;
  localparam logic [63:0] CV = 64'h80000001_fffffff0;
  logic             i_clk;
  logic             i_rst;
  logic             vld;
  logic [52:0]      rq;
  logic [9:0]       lvl;
  logic [9:0]       src;
  logic             rdy;
  logic             done;
  logic             spi;
  logic             msg;
  logic [31:0]      rdat;
  logic [31:0]      rd;
  logic [63:0]      cnt;
  logic [63:0]      v;
  logic [1:0][15:0] pci;
  logic [2:0]       f;
  logic             s;
  int               fail_count;
  int               n_compared;
  int               cyc;
  int               nmsg;
  int               seed;
  int               ids[7] = '{30, 29, 28, 27, 26, 20, 19};

  sct_top i_sct_top (.i_clk(i_clk), .i_rst(i_rst), .i_acc_valid(vld),
    .i_acc_write(rq[52]), .i_acc_secure(rq[51]), .i_acc_frame(rq[50:48]),
    .i_acc_timer(rq[47:44]), .i_acc_offset(rq[43:32]), .i_acc_wdata(rq[31:0]),
    .i_maint_irq(src[1:0]), .i_cross_trigger_irq(src[3:2]), .i_pmu_irq(src[5:4]),
    .i_debug_comms_irq(src[7:6]), .i_profiling_buffer_irq(src[9:8]),
    .o_acc_ready(rdy), .o_acc_done(done), .o_acc_rdata(rdat), .o_count(cnt),
    .o_per_core_interrupt(pci), .o_wakeup_spi(spi), .o_message_based_interrupt(msg));
  sct_core_src_model i_sct_core_src_model (.i_clk(i_clk), .i_lvl(lvl), .o_src(src));

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // called at a falling edge; holds the request over exactly one taking edge
  task automatic acc(input logic w, input logic sc, input logic [2:0] fr,
                     input logic [3:0] t, input logic [11:0] o, input logic [31:0] d);
    int k;
    k = 0;
    // let an edge pass so valid never falls and rises in one step
    @(negedge i_clk);
    while (!rdy) @(negedge i_clk);
    vld = 1;
    rq = {w, sc, fr, t, o, d};
    @(negedge i_clk);
    vld = 0;
    while (!done && k < 4) begin
      @(negedge i_clk);
      k++;
    end
    rd = rdat;
    chk("done", done, 1);
  endtask

  function automatic logic [32:0] want(input int e);
    want = (e == 14) ? 33'h100000000 : 33'h1 << ((e / 7) * 16 + ids[e % 7] - 16);
  endfunction

  function automatic logic [9:0] srcw(input logic [9:0] l);
    for (int c = 0; c < 2; c++)
      for (int k = 0; k < 5; k++)
        srcw[c * 5 + 4 - k] = l[k * 2 + c];
  endfunction

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    i_clk = 0;
    forever #2 i_clk = ~i_clk;
  end

  // a hang of the access handshake ends here
  always @(negedge i_clk) begin
    cyc++;
    if (msg)
      nmsg++;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end

  initial begin
    seed = 16057;
    i_rst = 1;
    vld = 0;
    rq = '0;
    lvl = '0;
    repeat (16) @(negedge i_clk);
    i_rst = 0;
    chk("count", cnt, 0);
    chk("ready", rdy, 1);
    acc(0, 1, 0, 0, 12'h020, 0);
    chk("freq", rd >= 32'h00989680, 1);
    acc(1, 1, 0, 0, 12'h008, CV[31:0]);
    acc(1, 1, 0, 0, 12'h00c, CV[63:32]);
    acc(1, 0, 0, 0, 12'h008, 32'h0);
    acc(0, 0, 0, 0, 12'h008, 0);
    chk("ns control", rd, 0);
    acc(0, 0, 1, 0, 12'h000, 0);
    chk("read lo", rd, CV[31:0]);
    acc(0, 0, 1, 0, 12'h004, 0);
    chk("read hi", rd, CV[63:32]);
    chk("count out", cnt, CV);
    acc(1, 1, 0, 0, 12'h000, 32'h1);
    repeat (40) @(negedge i_clk);
    acc(0, 1, 0, 0, 12'h008, 0);
    v[31:0] = rd;
    acc(0, 1, 0, 0, 12'h00c, 0);
    v[63:32] = rd;
    chk("atomic", (v - CV) inside {[64'h1e:64'h3c]}, 1);
    acc(0, 1, 0, 0, 12'h004, 0);
    chk("running", rd[0], 1);
    acc(1, 1, 0, 0, 12'h000, 32'h0);
    acc(1, 1, 0, 0, 12'h008, CV[31:0]);
    acc(1, 1, 0, 0, 12'h00c, CV[63:32]);
    acc(1, 0, 2, 0, 12'h080, 32'h1234abcd);
    acc(0, 1, 2, 0, 12'h080, 0);
    chk("voffset", rd, 0);
    $display("counter test done");
    // wakeup timer is entry 14 and is used from non-secure space
    for (int e = 0; e < 15; e++) begin
      f = (e == 14) ? 3'h3 : 3'h4;
      s = (e != 14);
      acc(1, s, f, e, 12'h024, CV[63:32]);
      acc(1, s, f, e, 12'h020, CV[31:0] + 32'h1);
      acc(1, s, f, e, 12'h02c, 32'h1);
      repeat (20) @(negedge i_clk);
      chk("early", {spi, pci}, 0);
      acc(1, s, f, e, 12'h020, CV[31:0]);
      repeat (20) @(negedge i_clk);
      chk("expired", {spi, pci}, want(e));
      acc(1, s, f, e, 12'h02c, 32'h3);
      acc(0, s, f, e, 12'h02c, 0);
      chk("status", rd, 32'h7);
      acc(0, 0, f, e, 12'h02c, 0);
      chk("ns status", rd, ((e % 7) inside {1, 5, 6}) ? 32'h0 : 32'h7);
      repeat (20) @(negedge i_clk);
      chk("masked", {spi, pci}, 0);
      acc(1, s, f, e, 12'h028, 32'h5);
      acc(0, s, f, e, 12'h020, 0);
      chk("tval cval", rd, CV[31:0] + 32'h5);
      acc(0, s, f, e, 12'h028, 0);
      chk("tval", rd, 32'h5);
      acc(1, s, f, e, 12'h02c, 32'h0);
    end
    chk("messages", nmsg, 1);
    $display("timer test done");
    for (int i = 0; i < 24; i++) begin
      lvl = $random(seed);
      repeat (3) @(negedge i_clk);
      chk("core src", {pci[1][9:5], pci[0][9:5]}, srcw(lvl));
    end
    $display("core source test done");
    results();
  end
endmodule
